// >>> rtl/bft_top.sv
// Two-stage breaker failure supervision: current flow detection and delay stages.
// Assumes settings and internal trips come from logic on CLK_IN, the external
// initiate from a binary input pin, and current samples at 16 per power cycle.
`include "bft_defines.svh"

// Functional notes
// [R1] Every protection trip also feeds this logic.
// [R2] Timers run only with trip and current.
// [R3] Current loss resets detector, halts both timers.
// [R4] First stage expiry asserts repeat trip.
// [R5] Second stage expiry asserts upstream trip.
// [R6] Detects interruption itself, not trip hold.
// [R7] Only fundamental component feeds flow comparison.
// [R8] Detection within half to one cycle.
// [R9] Flow true when magnitude at threshold.
// [R10] Trip plus flow initiates, starts both timers.
// [R11] No binary input can block initiation.
// [R12] External source ANDs pickup with trip.
// [R13] Single external initiate alone is accepted.
// [R14] Below threshold the breaker counts as open.
// [R15] Function switch off suppresses everything; CURRENT_FLOW_OUT still follows the flow criterion.
// [R16] Delays 0.10 to 10.00 s or infinite.
// [R17] Timers tick, restart, hold until drop.
module bft_top #(
    parameter int TICK_CYCLES = `BFT_TICK_CYCLES
) (
    input  wire logic                     CLK_IN,           // 125 MHz clock
    input  wire logic                     RESETN_IN,        // Synchronous reset, low
    input  wire bft_pkg::bft_cfg_s        CFG_IN,           // Settings
    input  wire logic [7:0]               PROT_TRIP_IN,     // Internal trip commands
    input  wire logic                     EXT_INITIATE_IN,  // External initiate pin
    input  wire logic [`BFT_SAMPLE_W-1:0] SAMPLE_IN,        // Signed current sample
    input  wire logic                     SAMPLE_VALID_IN,  // Sample strobe
    output logic                          REPEAT_TRIP_OUT,  // Trip to local breaker
    output logic                          UPSTREAM_TRIP_OUT,// Trip to busbar breakers
    output logic                          CURRENT_FLOW_OUT, // Current flow criterion
    output logic                          INITIATED_OUT,    // Timers running
    output logic                          FUNCTION_OFF_OUT  // Function switched off
);

    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (!RESETN_IN);

    // Rotating reference for the half-cycle Fourier filter, scaled by 127.
    function automatic logic signed [7:0] bft_cos(input logic [`BFT_PHASE_W-1:0] k);
        logic signed [7:0] c;
        c = 8'sh00;
        unique case (k)
            4'h0:    c = 8'sh7F;
            4'h1:    c = 8'sh75;
            4'h2:    c = 8'sh5A;
            4'h3:    c = 8'sh31;
            4'h4:    c = 8'sh00;
            4'h5:    c = -8'sh31;
            4'h6:    c = -8'sh5A;
            4'h7:    c = -8'sh75;
            4'h8:    c = -8'sh7F;
            4'h9:    c = -8'sh75;
            4'hA:    c = -8'sh5A;
            4'hB:    c = -8'sh31;
            4'hC:    c = 8'sh00;
            4'hD:    c = 8'sh31;
            4'hE:    c = 8'sh5A;
            4'hF:    c = 8'sh75;
        endcase
        return c;
    endfunction

    // Zero selects the default, out-of-range values clamp, all ones never expires.
    function automatic logic [`BFT_DELAY_W-1:0] bft_eff(input logic [`BFT_DELAY_W-1:0] d,
                                                        input logic [`BFT_DELAY_W-1:0] def);
        logic [`BFT_DELAY_W-1:0] r;
        r = d;
        if (d == 16'h0000) begin
            r = def;
        end else if (d == `BFT_DELAY_INFINITE) begin
            r = d;
        end else if (d < `BFT_DELAY_MIN_MS) begin
            r = `BFT_DELAY_MIN_MS;
        end else if (d > `BFT_DELAY_MAX_MS) begin
            r = `BFT_DELAY_MAX_MS;
        end
        return r;
    endfunction

    // External initiate pin synchroniser.
    logic                                ext_meta;
    logic                                ext_sync;

    always_ff @(posedge CLK_IN) begin
        if (!RESETN_IN) begin
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
        end else begin
            ext_meta <= EXT_INITIATE_IN;
            ext_sync <= ext_meta;
        end
    end

    // Fundamental-wave filter and current flow criterion.
    logic signed [`BFT_SAMPLE_W-1:0]     hist [`BFT_HALF_WINDOW];
    logic signed [`BFT_SAMPLE_W-1:0]     next_hist [`BFT_HALF_WINDOW];
    logic [`BFT_PHASE_W-1:0]             phase;
    logic [`BFT_PHASE_W-1:0]             next_phase;
    logic signed [`BFT_ACC_W-1:0]        acc_re;
    logic signed [`BFT_ACC_W-1:0]        next_acc_re;
    logic signed [`BFT_ACC_W-1:0]        acc_im;
    logic signed [`BFT_ACC_W-1:0]        next_acc_im;
    logic                                mag_upd;
    logic                                next_mag_upd;
    logic                                flow;
    logic                                next_flow;
    logic signed [`BFT_SAMPLE_W:0]       pair_sum;
    logic signed [24:0]                  prod_re;
    logic signed [24:0]                  prod_im;
    logic [`BFT_MAG_W-1:0]               abs_re;
    logic [`BFT_MAG_W-1:0]               abs_im;
    logic [`BFT_MAG_W-1:0]               mag;
    logic                                at_threshold;

    always_comb begin
        // The sample leaving the window has the opposite reference sign, so it adds.
        pair_sum    = $signed({SAMPLE_IN[`BFT_SAMPLE_W-1], SAMPLE_IN})
                    + $signed({hist[`BFT_HALF_WINDOW-1][`BFT_SAMPLE_W-1],
                               hist[`BFT_HALF_WINDOW-1]});
        prod_re     = pair_sum * bft_cos(phase);
        prod_im     = pair_sum * bft_cos(phase - 4'h4);
        next_hist   = hist;
        next_phase  = phase;
        next_acc_re = acc_re;
        next_acc_im = acc_im;
        next_mag_upd = SAMPLE_VALID_IN;
        if (SAMPLE_VALID_IN) begin // [R7] [R8]
            next_hist[0] = SAMPLE_IN;
            for (int i = 1; i < `BFT_HALF_WINDOW; i++) begin
                next_hist[i] = hist[i-1];
            end
            next_phase  = phase + 4'h1;
            next_acc_re = acc_re + `BFT_ACC_W'(prod_re);
            next_acc_im = acc_im + `BFT_ACC_W'(prod_im);
        end
        abs_re = acc_re[`BFT_ACC_W-1] ? `BFT_MAG_W'(-acc_re) : `BFT_MAG_W'(acc_re);
        abs_im = acc_im[`BFT_ACC_W-1] ? `BFT_MAG_W'(-acc_im) : `BFT_MAG_W'(acc_im);
        if (abs_re > abs_im) begin
            mag = abs_re + (abs_im >> 1);
        end else begin
            mag = abs_im + (abs_re >> 1);
        end
        at_threshold = mag >= `BFT_MAG_W'(CFG_IN.current_flow_threshold); // [R9] [R14]
        next_flow    = mag_upd ? at_threshold : flow; // [R3]
    end

    always_ff @(posedge CLK_IN) begin
        if (!RESETN_IN) begin
            for (int i = 0; i < `BFT_HALF_WINDOW; i++) begin
                hist[i] <= 16'sh0000;
            end
            phase   <= 4'h0;
            acc_re  <= 32'sh0000_0000;
            acc_im  <= 32'sh0000_0000;
            mag_upd <= 1'b0;
            flow    <= 1'b0;
        end else begin
            hist    <= next_hist;
            phase   <= next_phase;
            acc_re  <= next_acc_re;
            acc_im  <= next_acc_im;
            mag_upd <= next_mag_upd;
            flow    <= next_flow;
        end
    end

    // Initiation, delay stages and trip outputs.
    bft_pkg::bft_state_e                 state;
    bft_pkg::bft_state_e                 next_state;
    logic [`BFT_TICK_W-1:0]              div;
    logic [`BFT_TICK_W-1:0]              next_div;
    logic [`BFT_DELAY_W-1:0]             t1;
    logic [`BFT_DELAY_W-1:0]             next_t1;
    logic [`BFT_DELAY_W-1:0]             t2;
    logic [`BFT_DELAY_W-1:0]             next_t2;
    logic [`BFT_DELAY_W-1:0]             d1;
    logic [`BFT_DELAY_W-1:0]             d2;
    logic                                tick;
    logic                                any_trip;
    logic                                init_now;
    logic                                exp1;
    logic                                exp2;
    logic                                next_repeat;
    logic                                next_upstream;

    always_comb begin
        any_trip = (|PROT_TRIP_IN) | ext_sync; // [R1] [R13]
        // Only the function switch gates initiation; no input path can block it.
        init_now = CFG_IN.function_switch & any_trip & flow; // [R10] [R11] [R15]
        d1   = bft_eff(CFG_IN.backup_stage_delay, `BFT_BACKUP_DEF_MS); // [R16]
        d2   = bft_eff(CFG_IN.upstream_stage_delay, `BFT_UPSTREAM_DEF_MS); // [R16]
        exp1 = (d1 != `BFT_DELAY_INFINITE) && (t1 >= d1);
        exp2 = (d2 != `BFT_DELAY_INFINITE) && (t2 >= d2);
        tick = div == `BFT_TICK_W'(TICK_CYCLES - 1);
        next_div = div;
        next_t1  = t1;
        next_t2  = t2;
        if (!init_now) begin // [R2] [R3] [R6] [R17]
            next_div = '0;
            next_t1  = '0;
            next_t2  = '0;
        end else if (tick) begin // [R17]
            next_div = '0;
            if (t1 != `BFT_DELAY_INFINITE) begin
                next_t1 = t1 + 16'h0001;
            end
            if (t2 != `BFT_DELAY_INFINITE) begin
                next_t2 = t2 + 16'h0001;
            end
        end else begin
            next_div = div + 17'h00001;
        end
        next_repeat   = init_now & exp1; // [R4]
        next_upstream = init_now & exp2; // [R5]
        unique case (state)
            bft_pkg::BFT_ST_OFF,
            bft_pkg::BFT_ST_WATCH,
            bft_pkg::BFT_ST_TIMING: begin
                if (!CFG_IN.function_switch) begin
                    next_state = bft_pkg::BFT_ST_OFF;
                end else if (init_now) begin
                    next_state = bft_pkg::BFT_ST_TIMING;
                end else begin
                    next_state = bft_pkg::BFT_ST_WATCH;
                end
            end
            default: begin
                next_state = bft_pkg::BFT_ST_OFF;
            end
        endcase
    end

    always_ff @(posedge CLK_IN) begin
        if (!RESETN_IN) begin
            state             <= bft_pkg::BFT_ST_OFF;
            div               <= 17'h00000;
            t1                <= 16'h0000;
            t2                <= 16'h0000;
            REPEAT_TRIP_OUT   <= 1'b0;
            UPSTREAM_TRIP_OUT <= 1'b0;
            CURRENT_FLOW_OUT  <= 1'b0;
            INITIATED_OUT     <= 1'b0;
            FUNCTION_OFF_OUT  <= 1'b1;
        end else begin
            state             <= next_state;
            div               <= next_div;
            t1                <= next_t1;
            t2                <= next_t2;
            REPEAT_TRIP_OUT   <= next_repeat;
            UPSTREAM_TRIP_OUT <= next_upstream;
            CURRENT_FLOW_OUT  <= flow;
            INITIATED_OUT     <= init_now;
            FUNCTION_OFF_OUT  <= !CFG_IN.function_switch;
        end
    end

    a_repeat_needs_expiry: assert property ( // [R4]
        REPEAT_TRIP_OUT |-> $past(init_now) && $past(t1) >= $past(d1)
                            && $past(d1) != `BFT_DELAY_INFINITE)
        else $error("Repeat trip without expired first stage.");

    a_upstream_needs_flow: assert property ( // [R5]
        UPSTREAM_TRIP_OUT |-> $past(flow) && $past(t2) >= $past(d2))
        else $error("Upstream trip without current flow and expiry.");

    a_switch_off_quiet: assert property ( // [R15]
        !CFG_IN.function_switch |=> !REPEAT_TRIP_OUT && !UPSTREAM_TRIP_OUT
                                    && !INITIATED_OUT && FUNCTION_OFF_OUT)
        else $error("Outputs active while function is switched off.");

    // The timers still show the last count in the cycle where flow falls; they clear one later.
    a_flow_loss_halts: assert property ( // [R3]
        $fell(flow) |=> t1 == 16'h0000 && t2 == 16'h0000
                        && !REPEAT_TRIP_OUT && !UPSTREAM_TRIP_OUT)
        else $error("Timers not halted on loss of current.");

    a_flow_threshold: assert property ( // [R9]
        mag_upd |=> flow == $past(mag >= `BFT_MAG_W'(CFG_IN.current_flow_threshold)))
        else $error("Flow criterion disagrees with magnitude.");

    a_flow_held_between: assert property ( // [R14]
        !mag_upd |=> $stable(flow))
        else $error("Flow criterion changed without a new magnitude.");

    a_ext_single_channel: assert property ( // [R13]
        CFG_IN.function_switch && ext_sync && flow |=> INITIATED_OUT)
        else $error("External initiate alone did not initiate.");

    a_timer_tick_step: assert property ( // [R2]
        init_now && tick && t1 != `BFT_DELAY_INFINITE |=> t1 == $past(t1) + 16'h0001)
        else $error("First stage timer did not advance on tick.");

    a_restart_from_zero: assert property ( // [R17]
        !init_now |=> t1 == 16'h0000 && t2 == 16'h0000 && div == 17'h00000)
        else $error("Timers not cleared when initiation dropped.");

    a_trip_hold: assert property ( // [R17]
        REPEAT_TRIP_OUT && init_now |=> REPEAT_TRIP_OUT)
        else $error("Repeat trip dropped while initiation persists.");

    a_state_tracks_outs: assert property ( // [R15]
        (state == bft_pkg::BFT_ST_TIMING) == INITIATED_OUT
        && (state == bft_pkg::BFT_ST_OFF) == FUNCTION_OFF_OUT)
        else $error("State disagrees with initiation or switch outputs.");

endmodule // bft_top

// >>> rtl/bft_defines.svh
// Constants of the breaker failure timing block: offsets of time, counts, ranges.
// Assumes a 125 MHz system clock and a sampled current at 16 samples per cycle.
`ifndef BFT_DEFINES_SVH
`define BFT_DEFINES_SVH

`define BFT_CLK_PERIOD_NS    8
`define BFT_TICK_PERIOD_NS   1000000
`define BFT_TICK_CYCLES      (`BFT_TICK_PERIOD_NS / `BFT_CLK_PERIOD_NS)
`define BFT_TICK_W           17

`define BFT_DELAY_W          16
`define BFT_DELAY_MIN_MS     16'h0064
`define BFT_DELAY_MAX_MS     16'h2710
`define BFT_DELAY_INFINITE   16'hFFFF
`define BFT_BACKUP_DEF_MS    16'h01F4
`define BFT_UPSTREAM_DEF_MS  16'h02EE

`define BFT_SAMPLES_PER_CYC  16
`define BFT_HALF_WINDOW      8
`define BFT_PHASE_W          4
`define BFT_SAMPLE_W         16
`define BFT_ACC_W            32
`define BFT_MAG_W            33

`endif

// >>> rtl/bft_pkg.sv
// Types shared by the breaker failure timing block.
// Assumes bft_defines.svh is on the include path.
`include "bft_defines.svh"

package bft_pkg;

    typedef enum logic [1:0] {
        BFT_ST_OFF    = 2'b00,
        BFT_ST_WATCH  = 2'b01,
        BFT_ST_TIMING = 2'b10
    } bft_state_e;

    typedef struct packed {
        logic                         function_switch;
        logic [`BFT_ACC_W-1:0]        current_flow_threshold;
        logic [`BFT_DELAY_W-1:0]      backup_stage_delay;
        logic [`BFT_DELAY_W-1:0]      upstream_stage_delay;
    } bft_cfg_s;

endpackage

// >>> sim/bft_line_model.sv
// Far side model: a feeder breaker carrying a sinusoidal fault current and an external relay.
// Assumes one sample every 4 clocks, so one power cycle is 64 clocks.
module bft_line_model (
    input  wire logic        clk_in,           // Bench clock
    input  wire logic [15:0] amp_in,           // Fault current amplitude, 0 closes anew
    input  wire logic        trip_coil_in,     // Repeated trip to the second coil
    input  wire logic        coil_works_in,    // Breaker obeys the repeated trip
    input  wire logic        ext_pickup_in,    // External relay general pickup
    input  wire logic        ext_trip_in,      // External relay trip command
    output logic [15:0]      sample_out,       // Signed current sample
    output logic             valid_out,        // Sample strobe
    output logic             ext_initiate_out  // External initiate pin
);
    timeunit 1ns;
    timeprecision 1ps;
    int   tbl [8] = '{0, 49, 90, 117, 127, 117, 90, 49};
    int   phase = 0;
    int   div = 0;
    logic opened = 1'b0;

    // Two criteria guard the pin against a single faulty contact.
    assign ext_initiate_out = ext_pickup_in & ext_trip_in;

    initial begin
        sample_out = 16'h0000;
        valid_out  = 1'b0;
    end

    always @(negedge clk_in) begin
        int v;
        valid_out <= (div == 3);
        if (amp_in == 16'h0000) begin
            opened <= 1'b0;
        end else if (trip_coil_in && coil_works_in) begin
            opened <= 1'b1;
        end
        if (div == 3) begin
            v = opened ? 0 : int'(amp_in) * tbl[phase % 8] / 127;
            sample_out <= 16'(phase < 8 ? v : -v);
            phase      <= (phase + 1) % 16;
        end
        div <= (div + 1) % 4;
    end
endmodule // bft_line_model

// >>> sim/bft_top_bench.sv
// Self-checking bench of the breaker failure timing block, one task per scenario.
// Assumes the line model and a tick of 4 clocks per millisecond.
module bft_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TICK = 4;
    logic              clk = 1'b0;
    logic              rst_n = 1'b0;
    bft_pkg::bft_cfg_s cfg = '0;
    logic [7:0]        trip = 8'h00;
    logic [15:0]       amp = 16'h0000;
    logic              works = 1'b0;
    logic              pick = 1'b0;
    logic              xtrip = 1'b0;
    logic [15:0]       sample;
    logic              valid, ext, rep, up, flow, init, off;
    int                miscompares = 0;
    int                compares = 0;
    int                n;
    wire logic [3:0]   outs = {up, rep, init, flow};

    always #4 clk = ~clk;

    bft_top #(.TICK_CYCLES(TICK)) dut (
        .CLK_IN(clk), .RESETN_IN(rst_n), .CFG_IN(cfg), .PROT_TRIP_IN(trip),
        .EXT_INITIATE_IN(ext), .SAMPLE_IN(sample), .SAMPLE_VALID_IN(valid),
        .REPEAT_TRIP_OUT(rep), .UPSTREAM_TRIP_OUT(up), .CURRENT_FLOW_OUT(flow),
        .INITIATED_OUT(init), .FUNCTION_OFF_OUT(off));

    bft_line_model line (
        .clk_in(clk), .amp_in(amp), .trip_coil_in(rep), .coil_works_in(works),
        .ext_pickup_in(pick), .ext_trip_in(xtrip), .sample_out(sample),
        .valid_out(valid), .ext_initiate_out(ext));

    task finish_test;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task wait_for(input int s, input logic v, input int max);
        n = 0;
        while (outs[s] !== v && n < max) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask

    task setup(input logic [15:0] d1, input logic [15:0] d2);
        @(negedge clk);
        cfg = '{1'b1, 32'h00030D40, d1, d2};
        amp = 16'h03E8;
        wait_for(0, 1'b1, 200);
        check(flow, 1'b1);
        @(negedge clk);
    endtask

    // Drops every initiation and lets the filter see a full cycle of zero current.
    task idle;
        @(negedge clk);
        {trip, pick, xtrip, amp} = '0;
        repeat (100) @(posedge clk);
    endtask

    task t_two_stage;
        for (int k = 0; k < 2; k++) begin
            setup(16'h0064, 16'h0096);
            trip = 8'h01;
            wait_for(1, 1'b1, 4);
            check(init, 1'b1);
            wait_for(2, 1'b1, 1000);
            check(n, 100 * TICK);
            check(up, 1'b0);
            wait_for(3, 1'b1, 1000);
            check(n, 50 * TICK);
            @(negedge clk);
            trip = 8'h00;
            repeat (2) @(posedge clk);
            #1;
            check(outs, 4'h1);
            idle();
        end
    endtask

    task t_interrupt;
        setup(16'h0064, 16'h0096);
        trip = 8'h02;
        wait_for(1, 1'b1, 4);
        check(init, 1'b1);
        repeat (50 * TICK) @(posedge clk);
        @(negedge clk);
        amp = 16'h0000;
        wait_for(0, 1'b0, 100);
        check(32'(n <= 68), 32'h1);
        repeat (2) @(posedge clk);
        #1;
        check(init, 1'b0);
        repeat (100 * TICK) @(posedge clk);
        #1;
        check(outs, 4'h0);
        idle();
    endtask

    task t_repeat_clears;
        works = 1'b1;
        setup(16'h0064, 16'h00C8);
        trip = 8'h04;
        wait_for(2, 1'b1, 1000);
        check(rep, 1'b1);
        wait_for(3, 1'b1, 900);
        check(up, 1'b0);
        check(flow, 1'b0);
        check(rep, 1'b0);
        idle();
        works = 1'b0;
    endtask

    task t_ext;
        setup(16'h0001, 16'hFFFF);
        pick = 1'b1;
        repeat (8) @(posedge clk);
        #1;
        check(init, 1'b0);
        @(negedge clk);
        xtrip = 1'b1;
        wait_for(1, 1'b1, 8);
        check(init, 1'b1);
        wait_for(2, 1'b1, 1000);
        check(n, 100 * TICK);
        wait_for(3, 1'b1, 1000);
        check(up, 1'b0);
        idle();
    endtask

    task t_defaults;
        setup(16'h0000, 16'h00C8);
        trip = 8'h80;
        wait_for(1, 1'b1, 4);
        check(init, 1'b1);
        wait_for(3, 1'b1, 1000);
        check(n, 200 * TICK);
        check(rep, 1'b0);
        wait_for(2, 1'b1, 2000);
        check(n, 300 * TICK);
        idle();
    endtask

    task t_bits;
        setup(16'hFFFF, 16'hFFFF);
        for (int b = 0; b < 8; b++) begin
            trip = 8'h01 << b;
            wait_for(1, 1'b1, 4);
            check(init, 1'b1);
            @(negedge clk);
            trip = 8'h00;
            wait_for(1, 1'b0, 4);
            check(init, 1'b0);
            @(negedge clk);
        end
        idle();
    endtask

    task t_off_and_level;
        setup(16'h0064, 16'h0064);
        cfg.function_switch = 1'b0;
        trip = 8'hFF;
        repeat (100 * TICK + 8) @(posedge clk);
        #1;
        check(outs[3:1], 3'h0);
        check(off, 1'b1);
        idle();
        @(negedge clk);
        cfg.function_switch = 1'b1;
        amp = 16'h00C8;
        trip = 8'h01;
        repeat (200) @(posedge clk);
        #1;
        check(outs, 4'h0);
        check(off, 1'b0);
        idle();
    endtask

    initial begin
        repeat (40000) @(posedge clk);
        miscompares++;
        finish_test();
    end

    initial begin
        repeat (6) @(posedge clk);
        #1;
        check({outs, off}, 5'h01);
        @(negedge clk);
        rst_n = 1'b1;
        t_two_stage();
        t_interrupt();
        t_repeat_clears();
        t_ext();
        t_defaults();
        t_bits();
        t_off_and_level();
        finish_test();
    end
endmodule // bft_top_bench
